// file: mifc_top.sv
// Interrupt flag collector top: request capture, masks, global enable and APB slave.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mifc_top #(
    parameter int NUM_SOURCES = mifc_pkg::NUM_SRC
) (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    // Peripheral request levels, bank * 4 + bit
    input  wire logic [mifc_pkg::NUM_SRC-1:0]  src_req,
    // CPU core
    input  wire logic                          cpu_halt,
    output logic                               cpu_irq,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [mifc_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [mifc_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic [mifc_pkg::DATA_W-1:0]        prdata,
    output logic                               pready,
    output logic                               pslverr
);
    import mifc_pkg::*;

    // The flag layout is fixed at three nibbles
    if (NUM_SOURCES != NUM_BANK * BANK_W) begin : g_check
        $error("mifc_top supports exactly twelve request sources");
    end

    typedef struct packed {
        logic [NUM_SRC-1:0] masks;
        logic               global_irq_enable;
        logic               halt_prev;
        logic               pready;
        logic [DATA_W-1:0]  prdata;
        logic               pslverr;
        logic               irq;
    } mifc_state_t;

    mifc_state_t        st;
    mifc_state_t        next_st;
    logic [NUM_SRC-1:0] rise;
    logic [NUM_SRC-1:0] flags;
    logic [NUM_SRC-1:0] flag_clear;
    logic               access;
    logic               commit;
    logic               wr_en;
    logic               hit;
    logic [BANK_W-1:0]  read_nibble;
    logic [DATA_W-1:0]  read_word;

    // One synchroniser per source; port pins arrive from outside the clock
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        mifc_sync_edge u_sync (
            .ref_clk   (ref_clk),
            .sys_rst   (sys_rst),
            .src_level (src_req[i]),
            .rise      (rise[i])
        );
    end

    // Banks: port pins, timebase, peripherals
    for (genvar b = 0; b < NUM_BANK; b++) begin : g_bank
        mifc_flag_bank u_bank (
            .ref_clk   (ref_clk),
            .sys_rst   (sys_rst),
            .set_pulse (rise[b*BANK_W +: BANK_W]),
            .mask      (st.masks[b*BANK_W +: BANK_W]),
            .clear     (flag_clear[b*BANK_W +: BANK_W]),
            .flags     (flags[b*BANK_W +: BANK_W])
        );
    end

    // APB phases: first access cycle loads the answer, second completes
    assign access = psel & penable;
    assign commit = access & st.pready;
    assign wr_en  = commit & pwrite & pstrb[0];

    // Read value and decode of the addressed register
    always_comb begin
        read_nibble = RST_NIBBLE;
        hit         = 1'b1;
        read_word   = RST_WORD;
        case (paddr)
            OFS_PORT_FLAGS: read_nibble = flags[BANK_PORT*BANK_W +: BANK_W];
            OFS_TIME_FLAGS: read_nibble = flags[BANK_TIME*BANK_W +: BANK_W];
            OFS_PERI_FLAGS: read_nibble = flags[BANK_PERI*BANK_W +: BANK_W];
            OFS_PORT_MASKS: read_nibble = st.masks[BANK_PORT*BANK_W +: BANK_W];
            OFS_TIME_MASKS: read_nibble = st.masks[BANK_TIME*BANK_W +: BANK_W];
            OFS_PERI_MASKS: read_nibble = st.masks[BANK_PERI*BANK_W +: BANK_W];
            OFS_SYS_CTRL: begin
                read_nibble[GIE_BIT] = st.global_irq_enable;
                read_nibble[IRQ_BIT] = st.irq;
            end
            default: hit = 1'b0;
        endcase
        read_word[BANK_W-1:0] = read_nibble;
    end

    // Clears: a read drops only the bits it actually returned, a write the bits set in pwdata, so an edge
    // that lands between loading the answer and completion is not lost
    always_comb begin
        flag_clear = '0;
        if (commit) begin
            case (paddr)
                OFS_PORT_FLAGS: begin
                    flag_clear[BANK_PORT*BANK_W +: BANK_W] =
                        pwrite ? (wr_en ? pwdata[BANK_W-1:0] : RST_NIBBLE)
                               : st.prdata[BANK_W-1:0];
                end
                OFS_TIME_FLAGS: begin
                    flag_clear[BANK_TIME*BANK_W +: BANK_W] =
                        pwrite ? (wr_en ? pwdata[BANK_W-1:0] : RST_NIBBLE)
                               : st.prdata[BANK_W-1:0];
                end
                OFS_PERI_FLAGS: begin
                    flag_clear[BANK_PERI*BANK_W +: BANK_W] =
                        pwrite ? (wr_en ? pwdata[BANK_W-1:0] : RST_NIBBLE)
                               : st.prdata[BANK_W-1:0];
                end
                default: flag_clear = '0;
            endcase
        end
    end

    always_comb begin
        next_st           = st;
        next_st.halt_prev = cpu_halt;

        // Bus answer
        if (access && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.prdata  = pwrite ? RST_WORD : read_word;
            next_st.pslverr = ~hit;
        end else if (commit) begin
            next_st.pready  = 1'b0;
            next_st.prdata  = RST_WORD;
            next_st.pslverr = 1'b0;
        end

        // Register writes
        if (wr_en) begin
            case (paddr)
                OFS_PORT_MASKS: next_st.masks[BANK_PORT*BANK_W +: BANK_W] = pwdata[BANK_W-1:0];
                OFS_TIME_MASKS: next_st.masks[BANK_TIME*BANK_W +: BANK_W] = pwdata[BANK_W-1:0];
                OFS_PERI_MASKS: next_st.masks[BANK_PERI*BANK_W +: BANK_W] = pwdata[BANK_W-1:0];
                OFS_SYS_CTRL:   next_st.global_irq_enable = pwdata[GIE_BIT];
                default:        next_st.masks = st.masks;
            endcase
        end

        // Halt entry overrides a software clear in the same cycle
        if (cpu_halt && !st.halt_prev) begin
            next_st.global_irq_enable = 1'b1;
        end

        // Flags stay held until cleared, so pending work re-raises the line
        next_st.irq = (|flags) & st.global_irq_enable;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st.masks             <= '0;
            st.global_irq_enable <= 1'b0;
            st.halt_prev         <= 1'b0;
            st.pready            <= 1'b0;
            st.prdata            <= RST_WORD;
            st.pslverr           <= 1'b0;
            st.irq               <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign cpu_irq = st.irq;
    assign prdata  = st.prdata;
    assign pready  = st.pready;
    assign pslverr = st.pslverr;
endmodule

// file: mifc_pkg.sv
// Constants and register map of the maskable interrupt flag collector.
package mifc_pkg;
    localparam int         NUM_SRC   = 12;
    localparam int         BANK_W    = 4;
    localparam int         NUM_BANK  = 3;
    localparam int         ADDR_W    = 8;
    localparam int         DATA_W    = 32;
    // Byte addresses of the word registers
    localparam logic [7:0] OFS_PORT_FLAGS = 8'h00;
    localparam logic [7:0] OFS_TIME_FLAGS = 8'h04;
    localparam logic [7:0] OFS_PERI_FLAGS = 8'h08;
    localparam logic [7:0] OFS_PORT_MASKS = 8'h0C;
    localparam logic [7:0] OFS_TIME_MASKS = 8'h10;
    localparam logic [7:0] OFS_PERI_MASKS = 8'h14;
    localparam logic [7:0] OFS_SYS_CTRL   = 8'h18;
    // Bank indices
    localparam int         BANK_PORT = 0;
    localparam int         BANK_TIME = 1;
    localparam int         BANK_PERI = 2;
    // Fields of system_control_one
    localparam int         GIE_BIT   = 0;
    localparam int         IRQ_BIT   = 1;
    // Source positions inside the request vector (bank * 4 + bit)
    localparam int         SRC_PORT_PIN0   = 0;
    localparam int         SRC_PORT_PIN3   = 3;
    localparam int         SRC_MELODY      = 4;
    localparam int         SRC_BLINK       = 5;
    localparam int         SRC_FAST_TICK   = 6;
    localparam int         SRC_ONE_HERTZ   = 7;
    localparam int         SRC_CNT_COMPARE = 8;
    localparam int         SRC_CNT_ZERO    = 9;
    localparam int         SRC_MILLISEC    = 10;
    localparam int         SRC_SERIAL      = 11;
    // Reset values
    localparam logic [3:0]  RST_NIBBLE = 4'h0;
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
endpackage

// file: mifc_sync_edge.sv
// Three-stage synchroniser with a rising edge detector for one request source.
`timescale 1ns/1ps
module mifc_sync_edge (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Source and result
    input  wire logic src_level,
    output logic      rise
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
        logic rise;
    } mifc_sync_t;

    mifc_sync_t st;
    mifc_sync_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = src_level;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // A change counts only once the last two stages agree
        if (st.s2 == st.s3) begin
            next_st.stable = st.s3;
        end
        next_st.rise = st.s2 & st.s3 & ~st.stable;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rise = st.rise;
endmodule

// file: mifc_flag_bank.sv
// One four-bit bank of edge-set, maskable request flags.
`timescale 1ns/1ps
module mifc_flag_bank
    import mifc_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // Events, masks and clears
    input  wire logic [BANK_W-1:0] set_pulse,
    input  wire logic [BANK_W-1:0] mask,
    input  wire logic [BANK_W-1:0] clear,
    // Stored flags
    output logic [BANK_W-1:0]      flags
);
    typedef struct packed {
        logic [BANK_W-1:0] flags;
    } mifc_bank_t;

    mifc_bank_t st;
    mifc_bank_t next_st;

    always_comb begin
        next_st = st;
        // Masked edges are stored whatever the global enable says
        next_st.flags = (st.flags & ~clear) | (set_pulse & mask);
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st.flags <= RST_NIBBLE;
        end else begin
            st <= next_st;
        end
    end

    assign flags = st.flags;
endmodule

// file: mifc_top_chk.sv
// Port-level assertions for the interrupt flag collector.
`timescale 1ns/1ps
module mifc_top_chk
    import mifc_pkg::*;
#(
    parameter int NUM_SOURCES = NUM_SRC
) (
    // Clock and reset
    input wire logic               ref_clk,
    input wire logic               sys_rst,
    // Far side
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic               cpu_halt,
    input wire logic               cpu_irq,
    // APB
    input wire logic               psel,
    input wire logic               penable,
    input wire logic [ADDR_W-1:0]  paddr,
    input wire logic [DATA_W-1:0]  prdata,
    input wire logic               pready,
    input wire logic               pslverr
);
    logic [NUM_SRC-1:0] src_d;
    logic [3:0]         quiet;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Cycles with no cause that may move the line; the line must then hold still
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_d <= '0;
            quiet <= 4'h0;
        end else begin
            src_d <= src_req;
            if (src_req != src_d || pready || cpu_halt) begin
                quiet <= 4'h0;
            end else if (quiet != 4'hF) begin
                quiet <= quiet + 4'h1;
            end
        end
    end
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_pready_late: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not two cycles");
    chk_pready_cause: assert property (pready |-> psel && penable)
        else $error("pready outside a transfer");
    chk_err_unmapped: assert property (pready && paddr > OFS_SYS_CTRL |-> pslverr)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (pready && paddr <= OFS_SYS_CTRL && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("mapped access refused");
    chk_data_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero while idle");
    chk_data_upper: assert property (pready |-> prdata[31:4] == 28'h000_0000)
        else $error("prdata upper bits set");
    chk_irq_fall: assert property ($fell(cpu_irq) |-> $past(pready) || $past(pready, 2))
        else $error("interrupt dropped without an access");
    chk_irq_holds: assert property (quiet >= 4'd10 |-> $stable(cpu_irq))
        else $error("interrupt moved without a cause");
endmodule

// file: mifc_periph_model.sv
// Peripheral request sources and CPU halt line on the collector's far side.
`timescale 1ns/1ps
module mifc_periph_model (
    // Clock
    input  wire logic        ref_clk,
    // Bench commands
    input  wire logic [11:0] fire,
    input  wire logic        halt_cmd,
    // Request levels and halt state
    output logic [11:0]      src_req,
    output logic             cpu_halt
);
    logic [2:0] hold = 3'd0;
    initial src_req = 12'h000;
    initial cpu_halt = 1'b0;
    // A request stands four cycles so the three-flop synchroniser cannot miss it
    always @(posedge ref_clk) begin
        cpu_halt <= halt_cmd;
        if (fire != 12'h000) begin
            src_req <= fire;
            hold <= 3'd4;
        end else if (hold != 3'd0) begin
            hold <= hold - 3'd1;
            if (hold == 3'd1) begin
                src_req <= 12'h000;
            end
        end
    end
endmodule

// file: testbench.sv
// Self-checking bench for the interrupt flag collector.
`timescale 1ns/1ps
module testbench;
    import mifc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        sys_rst, cpu_halt, halt_cmd, cpu_irq, e;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] src_req, fire, m, f;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [31:0] seed = 32'h0000_4e32;
    int          failures = 0;
    int          total_checks = 0;
    always #4 ref_clk = ~ref_clk;
    mifc_top i_mifc_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .src_req(src_req),
        .cpu_halt(cpu_halt), .cpu_irq(cpu_irq), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    mifc_periph_model i_mifc_periph_model (.ref_clk(ref_clk), .fire(fire),
        .halt_cmd(halt_cmd), .src_req(src_req), .cpu_halt(cpu_halt));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] nib(input logic [11:0] v, input int b);
        return {28'h000_0000, v[b*4+:4]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // The master waits for pready itself; the design's latency is not assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) failures++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, x);
    endtask
    task automatic pulse(input logic [11:0] v);
        fire <= v;
        tick(1);
        fire <= 12'h000;
        tick(10);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        fire = 12'h000;
        halt_cmd = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        tick(12);
        sys_rst <= 1'b0;
        for (int b = 0; b < 7; b++) rd(8'(4 * b), 32'h0000_0000);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk({q[31:1], e}, 32'h0000_0001);
        repeat (4) begin
            m = 12'(xs());
            f = 12'(xs());
            for (int b = 0; b < 3; b++) apb(1'b1, 8'(12 + 4 * b), nib(m, b));
            for (int b = 0; b < 3; b++) rd(8'(12 + 4 * b), nib(m, b));
            pulse(f);
            // Software walks the banks in its own order to pick what to serve
            for (int b = 0; b < 3; b++) rd(8'(4 * b), nib(m & f, b));
            for (int b = 0; b < 3; b++) rd(8'(4 * b), 32'h0000_0000);
        end
        for (int b = 0; b < 3; b++) apb(1'b1, 8'(12 + 4 * b), 32'h0000_000F);
        pulse(12'hFFF);
        m = 12'(xs());
        apb(1'b1, OFS_PORT_FLAGS, nib(m, 0));
        rd(OFS_PORT_FLAGS, nib(~m, 0));
        for (int b = 1; b < 3; b++) rd(8'(4 * b), 32'h0000_000F);
        pulse(12'h010);
        chk({31'h0, cpu_irq}, 32'h0000_0000);
        apb(1'b1, OFS_SYS_CTRL, 32'h0000_0001);
        tick(2);
        chk({31'h0, cpu_irq}, 32'h0000_0001);
        rd(OFS_TIME_FLAGS, 32'h0000_0001);
        tick(2);
        chk({31'h0, cpu_irq}, 32'h0000_0000);
        pulse(12'h800);
        chk({31'h0, cpu_irq}, 32'h0000_0001);
        apb(1'b1, OFS_PERI_FLAGS, 32'h0000_0008);
        tick(2);
        chk({31'h0, cpu_irq}, 32'h0000_0000);
        // Edge timed so the flag sets at the very edge that commits the clearing write
        fire <= 12'h100;
        tick(1);
        fire <= 12'h000;
        tick(1);
        apb(1'b1, OFS_PERI_FLAGS, 32'h0000_0001);
        rd(OFS_PERI_FLAGS, 32'h0000_0001);
        apb(1'b1, OFS_SYS_CTRL, 32'h0000_0000);
        halt_cmd <= 1'b1;
        tick(3);
        halt_cmd <= 1'b0;
        rd(OFS_SYS_CTRL, 32'h0000_0001);
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        for (int b = 3; b < 7; b++) rd(8'(4 * b), 32'h0000_0000);
        stop_test();
    end
    // Whole sequence needs about four hundred cycles
    initial begin
        tick(20000);
        failures++;
        stop_test();
    end
endmodule
bind mifc_top mifc_top_chk #(.NUM_SOURCES(NUM_SOURCES)) u_chk (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .src_req(src_req), .cpu_halt(cpu_halt), .cpu_irq(cpu_irq),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
